// ===== logic/mpt_core.sv
// Purpose: Three-phase PWM timer, vector engine and digital port.
// Assumes: AXI4-Lite slave, one write and one read outstanding at most.
// Notes: PWM count, deadtime and transform timing advance on a system tick from a prescaler.
`timescale 1ns/1ns
module mpt_core
    import mpt_pkg::*;
(
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI write address
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // AXI write data
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI read address
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // AXI read data
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // PWM pins
    input  wire logic                pwm_stop,
    output logic [2:0]               pwm_hi,
    output logic [2:0]               pwm_lo,
    output logic                     pwm_sync,
    // Digital port
    input  wire logic [PIO_W-1:0]    pio_in,
    output logic [PIO_W-1:0]         pio_out,
    output logic [PIO_W-1:0]         pio_oe,
    // Interrupt
    output logic                     irq
);
    // Registers
    logic [DW-1:0]    ctrl_reg;
    logic [DW-1:0]    period_reg;
    logic [DW-1:0]    duty_reg [3];
    logic [DW-1:0]    duty_act [3];
    logic [DT_W-1:0]  dead_reg;
    logic [DEL_W-1:0] del_reg;
    logic [DW-1:0]    vx_reg;
    logic [DW-1:0]    vy_reg;
    logic [PIO_W-1:0] pdir_reg;
    logic [PIO_W-1:0] pout_reg;
    logic [PIO_W-1:0] plast_reg;
    logic [EV_W-1:0]  stat_reg;
    logic [EV_W-1:0]  ien_reg;
    // Bus state
    logic             wr_go;
    logic [7:0]       waddr;
    logic [DW-1:0]    wmask;
    logic [DW-1:0]    wval;
    logic             wr_hit;
    logic [DW-1:0]    rd_val;
    logic             rd_hit;
    // Timing state
    logic [5:0]       pre_reg;
    logic             tick;
    logic [DW-1:0]    cnt_reg;
    logic             up_reg;
    logic             run;
    logic             sync_ev;
    // Vector engine
    logic             v_start;
    logic             v_busy;
    logic             v_done;
    logic [DW-1:0]    v_r0;
    logic [DW-1:0]    v_r1;
    // Events
    logic             pio_ev;
    logic [EV_W-1:0]  ev;
    logic [EV_W-1:0]  clr;

    // Merge only the byte lanes the master enables
    function automatic logic [DW-1:0] mrg(input logic [DW-1:0] o);
        mrg = (o & ~wmask) | (wval & wmask);
    endfunction

    // Write address and data are taken together, one at a time
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign waddr = s_axi_awaddr;
    assign wval  = s_axi_wdata[DW-1:0];
    assign wmask = {{4{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign s_axi_arready = !s_axi_rvalid;

    // Decode of all mapped addresses, read-only ones included
    always_comb begin
        case (waddr)
            A_CTRL, A_PERIOD, A_DUTY_A, A_DUTY_B, A_DUTY_C,
            A_DEAD, A_DEL, A_VCMD, A_VX, A_VY, A_PDIR,
            A_POUT, A_ICLR, A_IEN, A_VR0, A_VR1, A_PIN,
            A_ISTAT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write response; read-only targets accept and ignore
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OK;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OK : RESP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes take effect at the accepting edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg    <= RST12;
            period_reg  <= RST12;
            duty_reg[0] <= RST12;
            duty_reg[1] <= RST12;
            duty_reg[2] <= RST12;
            dead_reg    <= '0;
            del_reg     <= '0;
            vx_reg      <= RST12;
            vy_reg      <= RST12;
            pdir_reg    <= '0;
            pout_reg    <= '0;
            ien_reg     <= '0;
        end else if (wr_go) begin
            case (waddr)
                A_CTRL:   ctrl_reg    <= mrg(ctrl_reg);
                A_PERIOD: period_reg  <= mrg(period_reg);
                A_DUTY_A: duty_reg[0] <= mrg(duty_reg[0]);
                A_DUTY_B: duty_reg[1] <= mrg(duty_reg[1]);
                A_DUTY_C: duty_reg[2] <= mrg(duty_reg[2]);
                A_DEAD:   dead_reg    <= DT_W'(mrg(DW'(dead_reg)));
                A_DEL:    del_reg     <= DEL_W'(mrg(DW'(del_reg)));
                A_VX:     vx_reg      <= mrg(vx_reg);
                A_VY:     vy_reg      <= mrg(vy_reg);
                A_PDIR:   pdir_reg    <= PIO_W'(mrg(DW'(pdir_reg)));
                A_POUT:   pout_reg    <= PIO_W'(mrg(DW'(pout_reg)));
                A_IEN:    ien_reg     <= EV_W'(mrg(DW'(ien_reg)));
                default:  ;
            endcase
        end
    end

    // A command write starts the engine; ignored while busy
    assign v_start = wr_go && (waddr == A_VCMD) && s_axi_wstrb[0];
    assign clr = (wr_go && waddr == A_ICLR && s_axi_wstrb[0]) ?
                 wval[EV_W-1:0] : '0;

    // Read mux; unused upper bits read as zero
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            A_CTRL: begin
                rd_val = ctrl_reg;
                rd_val[B_BUSY] = v_busy;
            end
            A_PERIOD: rd_val = period_reg;
            A_DUTY_A: rd_val = duty_reg[0];
            A_DUTY_B: rd_val = duty_reg[1];
            A_DUTY_C: rd_val = duty_reg[2];
            A_DEAD:   rd_val = DW'(dead_reg);
            A_DEL:    rd_val = DW'(del_reg);
            A_VCMD:   rd_val = RST12;
            A_VX:     rd_val = vx_reg;
            A_VY:     rd_val = vy_reg;
            A_VR0:    rd_val = v_r0;
            A_VR1:    rd_val = v_r1;
            A_PDIR:   rd_val = DW'(pdir_reg);
            A_POUT:   rd_val = DW'(pout_reg);
            A_PIN:    rd_val = DW'(pio_in);
            A_ISTAT:  rd_val = DW'(stat_reg);
            A_ICLR:   rd_val = RST12;
            A_IEN:    rd_val = DW'(ien_reg);
            default: begin
                rd_val = RST12;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read answer one cycle after the address; no read side effects
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OK;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {20'h00000, rd_val};
            s_axi_rresp  <= rd_hit ? RESP_OK : RESP_ERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // System tick: 12.5 MHz, or 6.25 MHz with the divide bit set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_reg <= '0;
        end else if (pre_reg == '0) begin
            pre_reg <= ctrl_reg[B_CLKDIV] ? 6'(2 * SYS_DIV - 1)
                                          : 6'(SYS_DIV - 1);
        end else begin
            pre_reg <= pre_reg - 1'b1;
        end
    end
    assign tick = (pre_reg == '0);

    // Stop pin forces every PWM output off at once
    assign run = ctrl_reg[B_RUN] && !pwm_stop;

    // Up/down count 0..period; wider pulses need a longer period
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_reg <= '0;
            up_reg  <= 1'b1;
        end else if (tick) begin
            if (period_reg == '0) begin
                cnt_reg <= '0;
            end else if (up_reg) begin
                if (cnt_reg >= period_reg) begin
                    up_reg  <= 1'b0;
                    cnt_reg <= cnt_reg - 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end else if (cnt_reg == '0) begin
                up_reg  <= 1'b1;
                cnt_reg <= cnt_reg + 1'b1;
            end else begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
    assign sync_ev = run && tick && !up_reg && (cnt_reg == '0);

    // Duties load at period start so a cycle never mixes values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_act[0] <= RST12;
            duty_act[1] <= RST12;
            duty_act[2] <= RST12;
            pwm_sync    <= 1'b0;
        end else begin
            pwm_sync <= sync_ev;
            if (sync_ev || !run) begin
                duty_act[0] <= duty_reg[0];
                duty_act[1] <= duty_reg[1];
                duty_act[2] <= duty_reg[2];
            end
        end
    end

    // One phase block per output pair
    mpt_phase u_ph_a (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick),
        .run     (run),
        .cnt     (cnt_reg),
        .duty    (duty_act[0]),
        .dead    (dead_reg),
        .del     (del_reg),
        .hi      (pwm_hi[0]),
        .lo      (pwm_lo[0])
    );
    mpt_phase u_ph_b (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick),
        .run     (run),
        .cnt     (cnt_reg),
        .duty    (duty_act[1]),
        .dead    (dead_reg),
        .del     (del_reg),
        .hi      (pwm_hi[1]),
        .lo      (pwm_lo[1])
    );
    mpt_phase u_ph_c (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick),
        .run     (run),
        .cnt     (cnt_reg),
        .duty    (duty_act[2]),
        .dead    (dead_reg),
        .del     (del_reg),
        .hi      (pwm_hi[2]),
        .lo      (pwm_lo[2])
    );

    // Transform engine
    mpt_vec u_vec (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick),
        .start   (v_start),
        .fwd     (wval[B_FWD]),
        .x       (vx_reg),
        .y       (vy_reg),
        .busy    (v_busy),
        .done    (v_done),
        .r0      (v_r0),
        .r1      (v_r1)
    );

    // Inputs assumed held two periods, so one sample per edge is safe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            plast_reg <= pio_in; // Track the pin: no false edge at release
        end else begin
            plast_reg <= pio_in;
        end
    end
    assign pio_ev  = |((pio_in ^ plast_reg) & ~pdir_reg);
    assign pio_out = pout_reg;
    assign pio_oe  = pdir_reg;

    // Sticky status: a new event wins over a clear in the same cycle
    assign ev = {v_done, sync_ev, pio_ev};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= (stat_reg & ~clr) | ev;
        end
    end
    assign irq = |(stat_reg & ien_reg);
endmodule

// ===== logic/mpt_pkg.sv
// Purpose: Constants for the motion PWM and vector transform core.
// Assumes: aclk at 250 MHz; system tick derived from it by a prescaler.
// Notes: What this block does, one line per tag:
package mpt_pkg;
    localparam int ACLK_KHZ   = 250000;
    localparam int SYS_KHZ    = 12500;
    localparam int SYS_DIV    = ACLK_KHZ / SYS_KHZ;
    localparam int SYS_NS     = 1000000 / SYS_KHZ;
    localparam int DT_MAX_NS  = 10080;
    localparam int DEL_MAX_NS = 10160;
    localparam int DT_STEPS   = DT_MAX_NS / SYS_NS / 2;
    localparam int DEL_MAX    = DEL_MAX_NS / SYS_NS;
    localparam int REV_CYC    = 37;
    localparam int FWD_CYC    = 40;
    localparam int DW         = 12;
    localparam int DT_W       = $clog2(DT_STEPS + 1);
    localparam int DEL_W      = $clog2(DEL_MAX + 1);
    localparam int PIO_W      = 6;
    // Register byte addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_PERIOD = 8'h04;
    localparam logic [7:0] A_DUTY_A = 8'h08;
    localparam logic [7:0] A_DUTY_B = 8'h0C;
    localparam logic [7:0] A_DUTY_C = 8'h10;
    localparam logic [7:0] A_DEAD   = 8'h14;
    localparam logic [7:0] A_DEL    = 8'h18;
    localparam logic [7:0] A_VCMD   = 8'h1C;
    localparam logic [7:0] A_VX     = 8'h20;
    localparam logic [7:0] A_VY     = 8'h24;
    localparam logic [7:0] A_VR0    = 8'h28;
    localparam logic [7:0] A_VR1    = 8'h2C;
    localparam logic [7:0] A_PDIR   = 8'h30;
    localparam logic [7:0] A_POUT   = 8'h34;
    localparam logic [7:0] A_PIN    = 8'h38;
    localparam logic [7:0] A_ISTAT  = 8'h3C;
    localparam logic [7:0] A_ICLR   = 8'h40;
    localparam logic [7:0] A_IEN    = 8'h44;
    // Field positions
    localparam int B_CLKDIV = 0;
    localparam int B_RUN    = 1;
    localparam int B_BUSY   = 2;
    localparam int B_FWD    = 0;
    localparam int E_PIO    = 0;
    localparam int E_SYNC   = 1;
    localparam int E_VEC    = 2;
    localparam int EV_W     = 3;
    // Transform gains, Q12
    localparam logic signed [13:0] K_INV_SQ3 = 14'sh093D;
    localparam logic signed [13:0] K_SQ3     = 14'sh1BB6;
    localparam logic [DW-1:0] RST12 = 12'h000;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// ===== logic/mpt_phase.sv
// Purpose: One complementary PWM phase with deletion and deadtime.
// Assumes: cnt is the shared up/down count, tick the system tick.
// Notes: Both outputs drop at once on any change of target.
`timescale 1ns/1ns
module mpt_phase
    import mpt_pkg::*;
(
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // Timing
    input  wire logic               tick,
    input  wire logic               run,
    input  wire logic [DW-1:0]      cnt,
    // Settings
    input  wire logic [DW-1:0]      duty,
    input  wire logic [DT_W-1:0]    dead,
    input  wire logic [DEL_W-1:0]   del,
    // Outputs
    output logic                    hi,
    output logic                    lo
);
    logic               raw;
    logic               want_reg;
    logic [DT_W:0]      dt_reg;

    // Pulse is 2*duty-1 ticks wide; too narrow a pulse is dropped
    assign raw = (cnt < duty) &&
                 ({1'b0, duty} >= {6'h00, del});

    // Turn-on waits 2*dead+1 ticks; turn-off is immediate
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            want_reg <= 1'b0;
            // Restart waits a full gap, the other side may just have been on
            dt_reg   <= {dead, 1'b0};
            hi       <= 1'b0;
            lo       <= 1'b0;
        end else if (tick) begin
            if (raw != want_reg) begin
                want_reg <= raw;
                dt_reg   <= {dead, 1'b0};
                hi       <= 1'b0;
                lo       <= 1'b0;
            end else if (dt_reg != '0) begin
                dt_reg <= dt_reg - 1'b1;
            end else begin
                hi <= want_reg;
                lo <= !want_reg;
            end
        end
    end
endmodule

// ===== logic/mpt_vec.sv
// Purpose: Clarke transform engine with fixed latency.
// Assumes: Operands stable while busy; start ignored when busy.
// Notes: Result appears with done after the full cycle count.
`timescale 1ns/1ns
module mpt_vec
    import mpt_pkg::*;
(
    // Clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 tick,
    // Command
    input  wire logic                 start,
    input  wire logic                 fwd,
    input  wire logic signed [DW-1:0] x,
    input  wire logic signed [DW-1:0] y,
    // Status and result
    output logic                      busy,
    output logic                      done,
    output logic signed [DW-1:0]      r0,
    output logic signed [DW-1:0]      r1
);
    logic        [5:0]  cnt_reg;
    logic               fwd_reg;
    logic signed [13:0] s;
    logic signed [27:0] p;
    logic signed [13:0] b;

    // Forward: beta=(x+2y)/sqrt3; reverse: b=(-alpha+sqrt3*beta)/2
    assign s = fwd_reg ? (14'(x) + (14'(y) <<< 1)) : 14'(y);
    assign p = s * (fwd_reg ? K_INV_SQ3 : K_SQ3);
    assign b = (14'(p >>> 12) - 14'(x)) >>> 1;

    // Count system ticks to the documented latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
            fwd_reg <= 1'b0;
            busy    <= 1'b0;
            done    <= 1'b0;
            r0      <= '0;
            r1      <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy    <= 1'b1;
                fwd_reg <= fwd;
                cnt_reg <= fwd ? 6'(FWD_CYC) : 6'(REV_CYC);
            end else if (busy && tick) begin
                cnt_reg <= cnt_reg - 1'b1;
                if (cnt_reg == 6'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    r0   <= x;
                    r1   <= fwd_reg ? DW'(p >>> 12) : DW'(b);
                end
            end
        end
    end
endmodule

// ===== bench/mpt_core_monitor.sv
// Purpose: Concurrent checks on the bus and PWM pins of the core.
// Assumes: One clock domain; synchronous active-low reset.
// Notes: Turn-on checks look 16 cycles back, under one system tick.
`timescale 1ns/1ns
module mpt_core_monitor
    import mpt_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write side
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read side
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // PWM pins
    input wire logic [2:0]  pwm_hi,
    input wire logic [2:0]  pwm_lo,
    input wire logic        pwm_sync
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Bus answers come one cycle after the take and stand until accepted
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_bresp_holds: assert property (
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_holds: assert property (
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_unmapped_err: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_awaddr > A_IEN
        |=> s_axi_bresp == RESP_ERR)
        else $error("unmapped write not refused");
    a_reg_width: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h00000)
        else $error("read data wider than a register");
    // A pair must never conduct together, and phase A turn-on waits a gap
    a_pair_apart: assert property ((pwm_hi & pwm_lo) == 3'h0)
        else $error("both switches of a phase on");
    a_hi_turn_on: assert property (
        $rose(pwm_hi[0]) |-> !$past(pwm_lo[0]) && !$past(pwm_lo[0], 16))
        else $error("high side on without deadtime");
    a_lo_turn_on: assert property (
        $rose(pwm_lo[0]) |-> !$past(pwm_hi[0]) && !$past(pwm_hi[0], 16))
        else $error("low side on without deadtime");
    a_sync_pulse: assert property (pwm_sync |=> !pwm_sync)
        else $error("sync pulse longer than one cycle");
endmodule

bind mpt_core mpt_core_monitor u_mon (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pwm_hi(pwm_hi), .pwm_lo(pwm_lo), .pwm_sync(pwm_sync)
);

// ===== bench/mpt_pin_model.sv
// Purpose: Outside driver of the digital port pins.
// Assumes: The bench asks for levels on drv; pins the core drives win.
// Notes: A new level waits until the old one has stood 40 cycles.
`timescale 1ns/1ns
module mpt_pin_model
    import mpt_pkg::*;
(
    // Clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    // Pins
    input wire logic [PIO_W-1:0] drv,
    input wire logic [PIO_W-1:0] pio_out,
    input wire logic [PIO_W-1:0] pio_oe,
    output logic [PIO_W-1:0]     pio_in
);
    logic [PIO_W-1:0] lvl_reg;
    int               hold_reg;

    // Hold each level two system periods so the core samples it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_reg  <= '0;
            hold_reg <= 0;
        end else if (drv != lvl_reg && hold_reg >= 40) begin
            lvl_reg  <= drv;
            hold_reg <= 0;
        end else if (hold_reg < 40) begin
            hold_reg <= hold_reg + 1;
        end
    end

    // Wire level: the core's driver wins where it is enabled
    assign pio_in = (pio_oe & pio_out) | (~pio_oe & lvl_reg);
endmodule

// ===== bench/test_mpt_core.sv
// Purpose: Register-level test of the PWM, vector and port core.
// Assumes: 250 MHz aclk, AXI4-Lite tasks, pin model on the port.
// Notes: Timing checks allow one system tick of phase slack.
`timescale 1ns/1ns
module test_mpt_core;
    import mpt_pkg::*;
    logic        aclk, aresetn, awv, awr, wv, wrd, bv, br;
    logic        arv, arr, rv, rr, stop, sync, irq;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd, dat;
    logic [3:0]  ws;
    logic [1:0]  bresp, rresp, resp;
    logic [2:0]  hi, lo, seen;
    logic [5:0]  pin, pout, poe, drv;
    int          err_total, compares, n;

    // Clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    mpt_core DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .pwm_stop(stop), .pwm_hi(hi), .pwm_lo(lo),
        .pwm_sync(sync), .pio_in(pin), .pio_out(pout), .pio_oe(poe),
        .irq(irq)
    );

    mpt_pin_model u_pins (
        .aclk(aclk), .aresetn(aresetn), .drv(drv), .pio_out(pout),
        .pio_oe(poe), .pio_in(pin)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Address and data go out together and stand until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awa <= a;
        wd  <= d;
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        do @(posedge aclk); while (!awr);
        awv <= 1'b0;
        wv  <= 1'b0;
        do @(posedge aclk); while (!bv);
        resp = bresp;
        br  <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
        dat  = rd;
        resp = rresp;
        rr  <= 1'b0;
    endtask

    // Cycles between two sync pulses; also gathers which high sides ran
    task automatic meas(output int cnt);
        do @(posedge aclk); while (!sync);
        cnt = 0;
        do begin
            @(posedge aclk);
            cnt++;
            seen = seen | hi;
        end while (!sync);
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Main sequence
    initial begin
        {aresetn, awv, wv, br, arv, rr, stop} = '0;
        {awa, ara, wd, drv, seen} = '0;
        ws        = 4'hF;
        err_total = 0;
        compares  = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset value, register width, reads without side effects
        rdr(A_PERIOD);
        check(dat, 32'h0000_0000);
        wr(A_PERIOD, 32'hFFFF_FFFF);
        rdr(A_PERIOD);
        check(dat, 32'h0000_0FFF);
        rdr(A_PERIOD);
        check(dat, 32'h0000_0FFF);
        wr(8'h48, 32'h0000_0001);
        check(32'(resp), 32'(RESP_ERR));
        rdr(8'h48);
        check(32'(resp), 32'(RESP_ERR));
        // Input change raises, masks and clears the interrupt
        wr(A_PDIR, 32'h0);
        wr(A_IEN, 32'h1);
        drv <= 6'h01;
        n = 0;
        while (!irq && n < 300) begin
            @(posedge aclk);
            n++;
        end
        check(32'(irq), 32'h1);
        rdr(A_ISTAT);
        check(dat, 32'h0000_0001);
        rdr(A_PIN);
        check(dat, 32'h0000_0001);
        wr(A_IEN, 32'h0);
        check(32'(irq), 32'h0);
        wr(A_ICLR, 32'h1);
        rdr(A_ISTAT);
        check(dat, 32'h0000_0000);
        // Port drives only where its direction bit is set
        wr(A_POUT, 32'h2A);
        wr(A_PDIR, 32'h30);
        check(32'({poe, pout}), 32'h0C2A);
        rdr(A_PIN);
        check(dat, 32'h0000_0021);
        // PWM: period 8 gives 16 ticks of 20 cycles between syncs
        wr(A_PERIOD, 32'h8);
        wr(A_DUTY_A, 32'h6);
        wr(A_DUTY_B, 32'h4);
        wr(A_DUTY_C, 32'h6);
        wr(A_DEAD, 32'h1);
        wr(A_DEL, 32'h5);
        wr(A_CTRL, 32'h2);
        meas(n);
        meas(n);
        check(32'(n), 32'd320);
        seen = 3'h0;
        meas(n);
        check(32'(seen[1]), 32'h0);
        check(32'(seen[0]), 32'h1);
        // Gap from low side off to high side on: three ticks
        do @(posedge aclk); while (!lo[0]);
        do @(posedge aclk); while (lo[0]);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!hi[0]);
        check(32'(n >= 40 && n <= 80), 32'h1);
        // Stop pin drops every switch at once
        stop <= 1'b1;
        repeat (2) @(posedge aclk);
        check(32'({hi, lo}), 32'h0);
        stop <= 1'b0;
        wr(A_CTRL, 32'h3);
        meas(n);
        meas(n);
        check(32'(n), 32'd640);
        wr(A_CTRL, 32'h0);
        // Vector engine: reverse then forward, timed by the done interrupt
        wr(A_VX, 32'h123);
        wr(A_VY, 32'h050);
        wr(A_IEN, 32'h4);
        for (int m = 0; m < 2; m++) begin
            wr(A_ICLR, 32'h7);
            wr(A_VCMD, 32'(m));
            rdr(A_CTRL);
            check(32'(dat[B_BUSY]), 32'h1);
            n = 0;
            while (!irq) begin
                @(posedge aclk);
                n++;
            end
            check(32'(n > (m ? 760 : 700) && n < (m ? 840 : 780)),
                  32'h1);
            rdr(A_VR0);
            check(dat, 32'h0000_0123);
            rdr(A_VR1);
            check(dat, m ? 32'h0000_0104 : 32'h0000_0FB3);
        end
        complete_run;
    end

    // Watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        repeat (50000) @(posedge aclk);
        err_total++;
        complete_run;
    end
endmodule
